/* File: sercfg_defs.svh */
/*
 * Offsets, field positions, reset values and timing counts of the serializer control register bank.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef SERCFG_DEFS_SVH
`define SERCFG_DEFS_SVH

`define OFS_BUS_ADDRESS 8'h00
`define OFS_POWER_RESET 8'h01
`define RST_BUS_ADDRESS 8'hB0
`define RST_POWER_RESET 8'h30
`define BIT_ADDR_SOURCE 0
`define BIT_DRIVE_SELECT 6
`define BIT_IO_AUTODETECT 5
`define BIT_IO_LEVEL 4
`define BIT_ANALOG_PWDN 3
`define BIT_LOGIC_RESET 1
`define BIT_FULL_RESET 0
`define RSV_POWER_RESET_MASK 8'h84
`define WR_POWER_RESET_MASK 8'h7B
`define RESET_PULSE_CYCLES 4

`endif

/* File: sercfg_pkg.sv */
/*
 * Types shared by the serializer control register bank.
 * Assumes sercfg_defs.svh is on the include path.
 */
`default_nettype none
`include "sercfg_defs.svh"

package sercfg_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [6:0] bus_addr_t;
	typedef enum logic
	{
		SRC_LOCAL,
		SRC_REMOTE
	} access_source_t;
endpackage

`default_nettype wire

/* File: sercfg_reset_pulse.sv */
/*
 * Stretches a one-cycle reset request into a pulse of a fixed number of cycles.
 * Assumes a synchronous active-high reset and a clock enable on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sercfg_defs.svh"

module sercfg_reset_pulse #(
	parameter int CYCLES = `RESET_PULSE_CYCLES
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic start_in,
	output logic busy_out
);
	logic [7:0] count_q;
	logic [7:0] count_d;

	always_comb
	begin
		count_d = count_q;
		if (start_in)
			count_d = 8'(CYCLES);
		else if (count_q != 8'h00)
			count_d = count_q - 8'h01;
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			count_q <= 8'h00;
		else if (ce_in)
			count_q <= count_d;
	end

	assign busy_out = (count_q != 8'h00);
endmodule

`default_nettype wire

/* File: sercfg_regs.sv */
/*
 * Serializer control register bank: own bus address, address source, drive strength,
 * I/O voltage control, analog power-down and two self-clearing digital resets.
 * Assumes byte-wide register accesses decoded by an upstream local bus controller or
 * the link back channel, each presented as a one-cycle strobe on clk_in.
 */
//
// Behaviour
// - Registers are read and written from local control port and remote channel.
// - Address register bits 7:1 hold own 7-bit address, default 0x58 (byte 0xB0).
// - Address bit 0 low uses strap pins; high uses programmed address.
// - Power register bit 6 selects high drive when 1, low drive when 0.
// - Power register bit 5 enables automatic I/O voltage detection when 1.
// - Power register bit 3 powers analog block down when 1, up when 0.
// - Analog power-down bit changes only on local writes; remote writes change it only through a full reset.
// - Power bit 1 resets logic keeping registers, then clears itself.
// - Power bit 0 resets all logic and registers to defaults, then clears itself; the bank resets its registers but holds logic_reset_out low.
//
`timescale 1ns/10ps
`default_nettype none
`include "sercfg_defs.svh"

module sercfg_regs
	import sercfg_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire sercfg_pkg::access_source_t src_in,
	input wire logic [7:0] addr_in,
	input wire sercfg_pkg::reg_byte_t wdata_in,
	input wire sercfg_pkg::bus_addr_t address_strap_pins_in,
	output sercfg_pkg::reg_byte_t rdata_out,
	output logic rvalid_out,
	output sercfg_pkg::bus_addr_t own_bus_address_out,
	output logic output_drive_select_out,
	output logic io_voltage_autodetect_out,
	output logic io_voltage_level_out,
	output logic analog_powerdown_out,
	output logic logic_reset_out
);
	import sercfg_pkg::*;

	// ****************************************
	// Strap synchroniser and register state
	// ****************************************
	bus_addr_t strap_meta_q;
	bus_addr_t strap_sync_q;
	reg_byte_t addr_reg_q;
	reg_byte_t addr_reg_d;
	reg_byte_t pwr_reg_q;
	reg_byte_t pwr_reg_d;
	reg_byte_t rdata_q;
	reg_byte_t rdata_d;
	logic rvalid_q;
	logic rvalid_d;
	bus_addr_t own_addr_q;
	bus_addr_t own_addr_d;
	logic full_req;
	logic logic_req;
	logic full_busy;
	logic logic_busy;
	logic lrst_q;
	logic bank_rst;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			strap_meta_q <= 7'h00;
			strap_sync_q <= 7'h00;
		end
		else if (ce_in)
		begin
			strap_meta_q <= address_strap_pins_in;
			strap_sync_q <= strap_meta_q;
		end
	end

	// ****************************************
	// Self-clearing reset pulses
	// ****************************************
	assign full_req = ce_in && wr_in && hit(addr_in, `OFS_POWER_RESET) && wdata_in[`BIT_FULL_RESET];
	assign logic_req = ce_in && wr_in && hit(addr_in, `OFS_POWER_RESET) && wdata_in[`BIT_LOGIC_RESET];
	assign bank_rst = srst_in || full_req || full_busy;

	sercfg_reset_pulse #(
		.CYCLES(`RESET_PULSE_CYCLES)
	) u_full_pulse (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.start_in(full_req),
		.busy_out(full_busy)
	);

	sercfg_reset_pulse #(
		.CYCLES(`RESET_PULSE_CYCLES)
	) u_logic_pulse (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.start_in(logic_req),
		.busy_out(logic_busy)
	);

	// ****************************************
	// Register writes and reads
	// ****************************************
	always_comb
	begin
		addr_reg_d = addr_reg_q;
		pwr_reg_d = pwr_reg_q;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		if (wr_in && hit(addr_in, `OFS_BUS_ADDRESS))
			addr_reg_d = wdata_in;
		if (wr_in && hit(addr_in, `OFS_POWER_RESET))
		begin
			pwr_reg_d = (pwr_reg_q & ~`WR_POWER_RESET_MASK) | (wdata_in & `WR_POWER_RESET_MASK);
			pwr_reg_d = (pwr_reg_d & ~`RSV_POWER_RESET_MASK) | (`RST_POWER_RESET & `RSV_POWER_RESET_MASK);
			if (src_in != SRC_LOCAL)
				pwr_reg_d[`BIT_ANALOG_PWDN] = pwr_reg_q[`BIT_ANALOG_PWDN];
			pwr_reg_d[`BIT_LOGIC_RESET] = 1'b0;
			pwr_reg_d[`BIT_FULL_RESET] = 1'b0;
		end
		if (rd_in)
		begin
			rvalid_d = 1'b1;
			if (hit(addr_in, `OFS_BUS_ADDRESS))
				rdata_d = addr_reg_q;
			else if (hit(addr_in, `OFS_POWER_RESET))
				rdata_d = pwr_reg_q;
			else
				rdata_d = 8'h00;
		end
		if (addr_reg_q[`BIT_ADDR_SOURCE])
			own_addr_d = addr_reg_q[7:1];
		else
			own_addr_d = strap_sync_q;
	end

	always_ff @(posedge clk_in)
	begin
		if (bank_rst)
		begin
			addr_reg_q <= `RST_BUS_ADDRESS;
			pwr_reg_q <= `RST_POWER_RESET;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
			own_addr_q <= 7'h00;
			lrst_q <= 1'b0;
		end
		else if (ce_in)
		begin
			addr_reg_q <= addr_reg_d;
			pwr_reg_q <= pwr_reg_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			own_addr_q <= own_addr_d;
			lrst_q <= logic_busy;
		end
	end

	assign rdata_out = rdata_q;
	assign rvalid_out = rvalid_q;
	assign own_bus_address_out = own_addr_q;
	assign output_drive_select_out = pwr_reg_q[`BIT_DRIVE_SELECT];
	assign io_voltage_autodetect_out = pwr_reg_q[`BIT_IO_AUTODETECT];
	assign io_voltage_level_out = pwr_reg_q[`BIT_IO_LEVEL];
	assign analog_powerdown_out = pwr_reg_q[`BIT_ANALOG_PWDN];
	assign logic_reset_out = lrst_q;

	// ****************************************
	// Checks
	// ****************************************
	property p_addr_default;
		@(posedge clk_in) $fell(srst_in) |-> addr_reg_q == 8'hB0;
	endproperty
	a_addr_default: assert property (p_addr_default) else $error("Address register not at default.");

	property p_strap_select;
		@(posedge clk_in) disable iff (bank_rst)
		ce_in && $past(ce_in) && !addr_reg_q[0] && $stable(addr_reg_q) && !$past(bank_rst)
		|=> own_bus_address_out == $past(strap_sync_q);
	endproperty
	a_strap_select: assert property (p_strap_select) else $error("Strap address not used.");

	property p_prog_select;
		@(posedge clk_in) disable iff (bank_rst)
		ce_in && addr_reg_q[0] |=> own_bus_address_out == $past(addr_reg_q[7:1]);
	endproperty
	a_prog_select: assert property (p_prog_select) else $error("Programmed address not used.");

	property p_drive_write;
		@(posedge clk_in) disable iff (bank_rst || full_req)
		ce_in && wr_in && addr_in == 8'h01 |=> output_drive_select_out == $past(wdata_in[6]);
	endproperty
	a_drive_write: assert property (p_drive_write) else $error("Drive select not written.");

	property p_auto_write;
		@(posedge clk_in) disable iff (bank_rst || full_req)
		ce_in && wr_in && addr_in == 8'h01 |=> io_voltage_autodetect_out == $past(wdata_in[5]);
	endproperty
	a_auto_write: assert property (p_auto_write) else $error("Autodetect bit not written.");

	property p_level_write;
		@(posedge clk_in) disable iff (bank_rst || full_req)
		ce_in && wr_in && addr_in == 8'h01 |=> io_voltage_level_out == $past(wdata_in[4]);
	endproperty
	a_level_write: assert property (p_level_write) else $error("Voltage level not written.");

	property p_local_pwdn;
		@(posedge clk_in) disable iff (bank_rst || full_req)
		ce_in && wr_in && addr_in == 8'h01 && src_in == SRC_LOCAL |=> analog_powerdown_out == $past(wdata_in[3]);
	endproperty
	a_local_pwdn: assert property (p_local_pwdn) else $error("Local power-down write lost.");

	property p_remote_pwdn;
		@(posedge clk_in) disable iff (bank_rst || full_req)
		ce_in && wr_in && src_in == SRC_REMOTE |=> $stable(analog_powerdown_out);
	endproperty
	a_remote_pwdn: assert property (p_remote_pwdn) else $error("Remote write changed power-down.");

	property p_logic_reset;
		@(posedge clk_in) disable iff (bank_rst || !ce_in)
		logic_req ##1 (ce_in && !wr_in) |=> logic_reset_out && $stable(addr_reg_q);
	endproperty
	a_logic_reset: assert property (p_logic_reset) else $error("Logic reset not raised.");

	property p_full_reset;
		@(posedge clk_in) disable iff (srst_in)
		full_req |=> addr_reg_q == 8'hB0 && pwr_reg_q == 8'h30;
	endproperty
	a_full_reset: assert property (p_full_reset) else $error("Full reset left registers.");

	property p_reset_bits_zero;
		@(posedge clk_in) disable iff (srst_in)
		pwr_reg_q[1:0] == 2'b00 && pwr_reg_q[7] == 1'b0 && pwr_reg_q[2] == 1'b0;
	endproperty
	a_reset_bits_zero: assert property (p_reset_bits_zero) else $error("Reserved or reset bit not default.");
endmodule

`default_nettype wire

/* File: reg_host_model.sv */
/*
 * Host model issuing single-byte register accesses on the strobe interface.
 * Assumes the testbench supplies the clock and calls the tasks after reset.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sercfg_defs.svh"

module reg_host_model
	import sercfg_pkg::*;
(
	input wire logic clk_in,
	output logic wr_out,
	output logic rd_out,
	output sercfg_pkg::access_source_t src_out,
	output logic [7:0] addr_out,
	output sercfg_pkg::reg_byte_t wdata_out,
	input wire sercfg_pkg::reg_byte_t rdata_in,
	input wire logic rvalid_in
);
	initial
	begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		src_out = SRC_LOCAL;
		addr_out = 8'h5A;
		wdata_out = 8'hA5;
	end

	// Released address and data lines show the inverse of their last value; src_out keeps its value.
	task automatic write_reg(input logic [7:0] a, input reg_byte_t d, input access_source_t s);
		@(posedge clk_in);
		#1;
		wr_out = 1'b1;
		addr_out = a;
		src_out = s;
		wdata_out = (a == `OFS_POWER_RESET) ? (d & ~`RSV_POWER_RESET_MASK) : d;
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~wdata_out;
	endtask

	task automatic read_reg(input logic [7:0] a, output reg_byte_t d, output logic ok);
		@(posedge clk_in);
		#1;
		rd_out = 1'b1;
		addr_out = a;
		@(posedge clk_in);
		#1;
		rd_out = 1'b0;
		addr_out = ~a;
		ok = rvalid_in;
		d = rdata_in;
	endtask
endmodule

`default_nettype wire

/* File: serializer_control_registers_tb.sv */
/*
 * Self-checking testbench of the serializer control register bank.
 * Assumes sercfg_pkg, sercfg_regs and reg_host_model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sercfg_defs.svh"

module serializer_control_registers_tb;
	import sercfg_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic wr, rd, rvalid, drive, auto_det, level, pwdn, lrst;
	access_source_t src;
	logic [7:0] addr;
	reg_byte_t wdata, rdata;
	bus_addr_t straps = 7'h2A;
	bus_addr_t own;
	int mismatches = 0;
	int total_checks = 0;
	logic [7:0] vals [6] = '{8'h78, 8'h40, 8'h20, 8'h10, 8'h08, 8'h00};

	always #2 clk = ~clk;

	sercfg_regs sercfg_regs_inst (.clk_in(clk), .srst_in(srst), .ce_in(ce), .wr_in(wr), .rd_in(rd),
		.src_in(src), .addr_in(addr), .wdata_in(wdata), .address_strap_pins_in(straps), .rdata_out(rdata),
		.rvalid_out(rvalid), .own_bus_address_out(own), .output_drive_select_out(drive),
		.io_voltage_autodetect_out(auto_det), .io_voltage_level_out(level), .analog_powerdown_out(pwdn),
		.logic_reset_out(lrst));

	reg_host_model reg_host_model_inst (.clk_in(clk), .wr_out(wr), .rd_out(rd), .src_out(src),
		.addr_out(addr), .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		reg_byte_t d;
		logic ok;
		reg_host_model_inst.read_reg(a, d, ok);
		chk({7'h00, ok}, 8'h01);
		chk(d, exp);
	endtask

	task automatic fchk(input logic [7:0] exp);
		@(posedge clk);
		#1;
		chk({1'b0, drive, auto_det, level, pwdn, 3'b000}, exp);
	endtask

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		#20000;
		mismatches++;
		conclude();
	end

	// ****************************************
	// Test sequence.
	// ****************************************
	initial
	begin
		repeat (10) @(posedge clk);
		#1;
		srst = 1'b0;
		rchk(`OFS_BUS_ADDRESS, `RST_BUS_ADDRESS);
		rchk(`OFS_POWER_RESET, `RST_POWER_RESET);
		chk({1'b0, own}, 8'h2A);
		rchk(8'h02, 8'h00);
		reg_host_model_inst.write_reg(`OFS_BUS_ADDRESS, 8'h97, SRC_LOCAL);
		repeat (3) @(posedge clk);
		#1;
		chk({1'b0, own}, 8'h4B);
		rchk(`OFS_BUS_ADDRESS, 8'h97);
		ce = 1'b0;
		reg_host_model_inst.write_reg(`OFS_BUS_ADDRESS, 8'h55, SRC_LOCAL);
		ce = 1'b1;
		rchk(`OFS_BUS_ADDRESS, 8'h97);
		reg_host_model_inst.write_reg(`OFS_BUS_ADDRESS, 8'h33, SRC_REMOTE);
		repeat (3) @(posedge clk);
		#1;
		chk({1'b0, own}, 8'h19);
		for (int i = 0; i < 6; i++)
		begin
			reg_host_model_inst.write_reg(`OFS_POWER_RESET, vals[i], SRC_LOCAL);
			fchk(vals[i]);
			rchk(`OFS_POWER_RESET, vals[i]);
		end
		reg_host_model_inst.write_reg(`OFS_POWER_RESET, 8'h48, SRC_REMOTE);
		fchk(8'h40);
		reg_host_model_inst.write_reg(`OFS_POWER_RESET, 8'h08, SRC_LOCAL);
		reg_host_model_inst.write_reg(`OFS_POWER_RESET, 8'h00, SRC_REMOTE);
		fchk(8'h08);
		reg_host_model_inst.write_reg(`OFS_POWER_RESET, 8'h0A, SRC_LOCAL);
		for (int i = 0; i < 8 && lrst !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
		chk({7'h00, lrst}, 8'h01);
		repeat (8) @(posedge clk);
		#1;
		chk({7'h00, lrst}, 8'h00);
		rchk(`OFS_POWER_RESET, 8'h08);
		rchk(`OFS_BUS_ADDRESS, 8'h33);
		reg_host_model_inst.write_reg(`OFS_POWER_RESET, 8'h09, SRC_LOCAL);
		repeat (6) @(posedge clk);
		rchk(`OFS_BUS_ADDRESS, `RST_BUS_ADDRESS);
		rchk(`OFS_POWER_RESET, `RST_POWER_RESET);
		fchk(`RST_POWER_RESET);
		chk({1'b0, own}, 8'h2A);
		conclude();
	end
endmodule

`default_nettype wire
